// [smu_serial_comm_unit.v]
// Purpose: async serial transmitter/receiver with multiprocessor mode and AHB-Lite registers
// Assumes: one clock, basic clock is 16x bit rate from an internal divider
// Notes: zero wait states, response always OKAY
`timescale 1ns/1ps
`default_nettype none
`include "smu_defs.vh"
module smu_serial_comm_unit (
  // clock and reset
  input wire i_clk,
  input wire i_arst_n,
  // ahb-lite slave
  input wire i_hsel,
  input wire [31:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire [2:0] i_hsize,
  input wire [31:0] i_hwdata,
  input wire i_hready,
  output wire [31:0] o_hrdata,
  output wire o_hreadyout,
  output wire o_hresp,
  // serial lines
  input wire i_rxd,
  output reg o_txd,
  // interrupt requests
  output wire o_tx_empty_irq,
  output wire o_tx_end_irq,
  output wire o_rx_full_irq,
  output wire o_rx_error_irq
);
  localparam TX_IDLE = 3'd0;
  localparam TX_START = 3'd1;
  localparam TX_DATA = 3'd2;
  localparam TX_EXTRA = 3'd3;
  localparam TX_STOP = 3'd4;
  localparam RX_IDLE = 3'd0;
  localparam RX_START = 3'd1;
  localparam RX_DATA = 3'd2;
  localparam RX_EXTRA = 3'd3;
  localparam RX_STOP = 3'd4;
  // reset status word, split into its flags so the reset branch stays constant
  localparam [7:0] RST_ST = `SMU_RST_STATUS;

  // data bits for the selected length
  function [3:0] nbits;
    input chr7;
    begin
      nbits = chr7 ? 4'd7 : 4'd8;
    end
  endfunction

  // parity over the active data bits, odd when odd is 1
  function par_of;
    input [7:0] d;
    input chr7;
    input odd;
    begin
      par_of = ^(chr7 ? {1'b0, d[6:0]} : d) ^ odd;
    end
  endfunction

  // registers
  reg [7:0] fmt_q;
  reg [7:0] ctl_q;
  reg [15:0] div_q;
  reg [7:0] tx_buffer_q;
  reg [7:0] rx_buffer_q;
  reg tx_buffer_empty_flag_q, tx_end_flag_q, rx_full_flag_q, per_q, fer_q, overrun_flag_q, mpb_q, tx_multiproc_bit_q;

  wire tick;
  wire rx_line;
  smu_tick_gen u_tick (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_div(div_q),
    .o_tick(tick)
  );
  smu_rx_sync u_sync (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_line(i_rxd),
    .o_line(rx_line)
  );

  wire te = ctl_q[`SMU_CTL_TE];
  wire re = ctl_q[`SMU_CTL_RE];
  wire mp_fmt = fmt_q[`SMU_FMT_MP];
  wire chr7 = fmt_q[`SMU_FMT_CHR7];
  wire par_en = fmt_q[`SMU_FMT_PE] & ~mp_fmt;
  wire extra_en = par_en | mp_fmt;

  // ---------- bus address phase capture ----------
  reg ap_wr_q, ap_rd_q;
  reg [3:0] ap_addr_q;
  reg ap_hi_q;
  wire ap_valid = i_hsel & i_hready & i_htrans[1];
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ap_wr_q <= 1'b0;
      ap_rd_q <= 1'b0;
      ap_addr_q <= 4'h0;
      ap_hi_q <= 1'b0;
    end else begin
      ap_wr_q <= ap_valid & i_hwrite;
      ap_rd_q <= ap_valid & ~i_hwrite;
      ap_addr_q <= i_haddr[3:0];
      ap_hi_q <= i_haddr[4];
    end
  end
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;

  wire wr = ap_wr_q;
  wire wr_fmt = wr & ~ap_hi_q & (ap_addr_q == `SMU_ADDR_FORMAT);
  wire wr_ctl = wr & ~ap_hi_q & (ap_addr_q == `SMU_ADDR_CONTROL);
  wire wr_st = wr & ~ap_hi_q & (ap_addr_q == `SMU_ADDR_STATUS);
  wire wr_txd = wr & ~ap_hi_q & (ap_addr_q == `SMU_ADDR_TXDATA);
  wire wr_div = wr & ap_hi_q & (ap_addr_q == `SMU_ADDR_DIVIDER);

  // read data registered during address phase so it stands in data phase
  reg [31:0] rdata_q;
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_q <= 32'h00000000;
    end else if (ap_valid & ~i_hwrite) begin
      case ({i_haddr[4], i_haddr[3:0]})
        {1'b0, `SMU_ADDR_FORMAT}: rdata_q <= {24'h000000, fmt_q};
        {1'b0, `SMU_ADDR_CONTROL}: rdata_q <= {24'h000000, ctl_q};
        {1'b0, `SMU_ADDR_STATUS}: rdata_q <= {24'h000000, tx_buffer_empty_flag_q, rx_full_flag_q, overrun_flag_q, fer_q, per_q, tx_end_flag_q, mpb_q, tx_multiproc_bit_q};
        {1'b0, `SMU_ADDR_TXDATA}: rdata_q <= {24'h000000, tx_buffer_q};
        {1'b1, `SMU_ADDR_RXDATA}: rdata_q <= {24'h000000, rx_buffer_q};
        {1'b1, `SMU_ADDR_DIVIDER}: rdata_q <= {16'h0000, div_q};
        default: rdata_q <= 32'h00000000;
      endcase
    end
  end
  assign o_hrdata = rdata_q;

  // ---------- transmitter ----------
  reg [2:0] tx_st_q;
  reg [3:0] tx_tick_q;
  reg [3:0] tx_bit_q;
  reg [7:0] tsr_q;
  reg tx_extra_q;
  reg tx_stop2_q;
  wire tx_bit_end = tick & (tx_tick_q == `SMU_LAST_TICK);
  // load happens at entry to the stop bit or when idle
  wire tx_load_idle = te & (tx_st_q == TX_IDLE) & ~tx_buffer_empty_flag_q;
  reg tx_load_stop;
  wire tx_load = tx_load_idle | tx_load_stop;
  reg tx_next_q;

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tx_st_q <= TX_IDLE;
      tx_tick_q <= 4'h0;
      tx_bit_q <= 4'h0;
      tsr_q <= 8'h00;
      tx_extra_q <= 1'b0;
      tx_stop2_q <= 1'b0;
      tx_next_q <= 1'b0;
      tx_load_stop <= 1'b0;
      o_txd <= 1'b1;
    end else begin
      tx_load_stop <= 1'b0;
      if (tick) begin
        tx_tick_q <= tx_tick_q + 4'h1;
      end
      if (!te) begin
        tx_st_q <= TX_IDLE;
        tx_next_q <= 1'b0;
        o_txd <= 1'b1;
      end else begin
        case (tx_st_q)
          TX_IDLE: begin
            o_txd <= 1'b1;
            if (tx_load_idle) begin
              tsr_q <= tx_buffer_q;
              tx_extra_q <= mp_fmt ? tx_multiproc_bit_q : par_of(tx_buffer_q, chr7, fmt_q[`SMU_FMT_PODD]);
              tx_tick_q <= 4'h0;
              tx_st_q <= TX_START;
              o_txd <= 1'b0;
            end
          end
          TX_START: begin
            if (tx_bit_end) begin
              tx_bit_q <= 4'h0;
              o_txd <= tsr_q[0];
              tx_st_q <= TX_DATA;
            end
          end
          TX_DATA: begin
            if (tx_bit_end) begin
              if (tx_bit_q == nbits(chr7) - 4'd1) begin
                if (extra_en) begin
                  o_txd <= tx_extra_q;
                  tx_st_q <= TX_EXTRA;
                end else begin
                  o_txd <= 1'b1;
                  tx_stop2_q <= fmt_q[`SMU_FMT_STOP2];
                  tx_next_q <= ~tx_buffer_empty_flag_q;
                  tx_load_stop <= ~tx_buffer_empty_flag_q;
                  tx_st_q <= TX_STOP;
                end
              end else begin
                tx_bit_q <= tx_bit_q + 4'd1;
                o_txd <= tsr_q[tx_bit_q[2:0] + 3'd1];
              end
            end
          end
          TX_EXTRA: begin
            if (tx_bit_end) begin
              o_txd <= 1'b1;
              tx_stop2_q <= fmt_q[`SMU_FMT_STOP2];
              tx_next_q <= ~tx_buffer_empty_flag_q;
              tx_load_stop <= ~tx_buffer_empty_flag_q;
              tx_st_q <= TX_STOP;
            end
          end
          TX_STOP: begin
            if (tx_load_stop) begin
              tsr_q <= tx_buffer_q;
              tx_extra_q <= mp_fmt ? tx_multiproc_bit_q : par_of(tx_buffer_q, chr7, fmt_q[`SMU_FMT_PODD]);
            end
            if (tx_bit_end) begin
              if (tx_stop2_q) begin
                tx_stop2_q <= 1'b0;
              end else if (tx_next_q) begin
                tx_next_q <= 1'b0;
                o_txd <= 1'b0;
                tx_st_q <= TX_START;
              end else begin
                o_txd <= 1'b1;
                tx_st_q <= TX_IDLE;
              end
            end
          end
          default: tx_st_q <= TX_IDLE;
        endcase
      end
    end
  end
  wire tx_end_evt = te & tx_bit_end & ((tx_st_q == TX_EXTRA) |
    ((tx_st_q == TX_DATA) & ~extra_en & (tx_bit_q == nbits(chr7) - 4'd1))) & tx_buffer_empty_flag_q;

  // ---------- receiver ----------
  reg [2:0] rx_st_q;
  reg [3:0] rx_tick_q;
  reg [3:0] rx_bit_q;
  reg [7:0] rsr_q;
  reg rx_extra_q;
  wire rx_err_any = overrun_flag_q | fer_q | per_q;
  wire rx_mid = tick & (rx_tick_q == `SMU_MID_TICK);
  reg rx_done;
  reg rx_stop_bit;

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rx_st_q <= RX_IDLE;
      rx_tick_q <= 4'h0;
      rx_bit_q <= 4'h0;
      rsr_q <= 8'h00;
      rx_extra_q <= 1'b0;
      rx_done <= 1'b0;
      rx_stop_bit <= 1'b1;
    end else begin
      rx_done <= 1'b0;
      if (tick) begin
        rx_tick_q <= rx_tick_q + 4'h1;
      end
      if (!re) begin
        rx_st_q <= RX_IDLE;
      end else begin
        case (rx_st_q)
          RX_IDLE: begin
            if (!rx_line & !rx_err_any) begin
              rx_tick_q <= 4'h0;
              rx_st_q <= RX_START;
            end
          end
          RX_START: begin
            if (rx_mid) begin
              if (rx_line) begin
                rx_st_q <= RX_IDLE;
              end else begin
                rx_bit_q <= 4'h0;
                rx_st_q <= RX_DATA;
              end
            end
          end
          RX_DATA: begin
            if (rx_mid) begin
              rsr_q <= {rx_line, rsr_q[7:1]};
              if (rx_bit_q == nbits(chr7) - 4'd1) begin
                rx_st_q <= extra_en ? RX_EXTRA : RX_STOP;
              end else begin
                rx_bit_q <= rx_bit_q + 4'd1;
              end
            end
          end
          RX_EXTRA: begin
            if (rx_mid) begin
              rx_extra_q <= rx_line;
              rx_st_q <= RX_STOP;
            end
          end
          RX_STOP: begin
            if (rx_mid) begin
              if (chr7) begin
                rsr_q <= {1'b0, rsr_q[7:1]};
              end
              rx_stop_bit <= rx_line;
              rx_done <= 1'b1;
              rx_st_q <= RX_IDLE;
            end
          end
          default: rx_st_q <= RX_IDLE;
        endcase
      end
    end
  end

  wire rx_id = mp_fmt & rx_extra_q;
  wire rx_skip = mp_fmt & ctl_q[`SMU_CTL_MULTIPROC_WAIT_ENABLE] & ~rx_extra_q;
  wire rx_take = rx_done & ~rx_skip;
  wire rx_ovr = rx_take & rx_full_flag_q;
  wire rx_fer = rx_take & ~rx_stop_bit;
  wire rx_per = rx_take & par_en & (rx_extra_q != par_of(rsr_q, chr7, fmt_q[`SMU_FMT_PODD]));
  wire rx_ok = rx_take & ~rx_ovr & ~rx_fer & ~rx_per;
  wire rx_store = rx_take & ~rx_ovr;

  // ---------- software registers and flags ----------
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fmt_q <= 8'h00;
      ctl_q <= 8'h00;
      div_q <= `SMU_RST_DIVIDER;
      tx_buffer_q <= 8'h00;
      rx_buffer_q <= 8'h00;
      tx_buffer_empty_flag_q <= RST_ST[`SMU_ST_TX_BUFFER_EMPTY_FLAG];
      tx_end_flag_q <= RST_ST[`SMU_ST_TX_END_FLAG];
      rx_full_flag_q <= 1'b0;
      per_q <= 1'b0;
      fer_q <= 1'b0;
      overrun_flag_q <= 1'b0;
      mpb_q <= 1'b0;
      tx_multiproc_bit_q <= 1'b0;
    end else begin
      if (wr_fmt) fmt_q <= i_hwdata[7:0];
      if (wr_div) div_q <= i_hwdata[15:0];
      if (wr_ctl) ctl_q <= i_hwdata[7:0];
      if (rx_take & rx_id) ctl_q[`SMU_CTL_MULTIPROC_WAIT_ENABLE] <= 1'b0;
      if (wr_txd) begin
        tx_buffer_q <= i_hwdata[7:0];
        tx_buffer_empty_flag_q <= 1'b0;
        tx_end_flag_q <= 1'b0;
      end
      // software clears status flags by writing 0; hardware set wins
      if (wr_st) begin
        tx_multiproc_bit_q <= i_hwdata[`SMU_ST_TX_MULTIPROC_BIT];
        if (!i_hwdata[`SMU_ST_TX_BUFFER_EMPTY_FLAG]) tx_buffer_empty_flag_q <= 1'b0;
        if (!i_hwdata[`SMU_ST_TX_END_FLAG]) tx_end_flag_q <= 1'b0;
        if (!i_hwdata[`SMU_ST_RX_FULL_FLAG]) rx_full_flag_q <= 1'b0;
        if (!i_hwdata[`SMU_ST_PER]) per_q <= 1'b0;
        if (!i_hwdata[`SMU_ST_FER]) fer_q <= 1'b0;
        if (!i_hwdata[`SMU_ST_OVERRUN_FLAG]) overrun_flag_q <= 1'b0;
        if (!i_hwdata[`SMU_ST_MPB]) mpb_q <= 1'b0;
      end
      if (tx_load) tx_buffer_empty_flag_q <= 1'b1;
      if (wr_ctl & ~i_hwdata[`SMU_CTL_TE]) tx_buffer_empty_flag_q <= 1'b1;
      if (tx_end_evt) tx_end_flag_q <= 1'b1;
      // rx enable clears nothing here, flags and buffer are kept
      if (rx_store) rx_buffer_q <= rsr_q;
      if (rx_ok) rx_full_flag_q <= 1'b1;
      if (rx_ovr) overrun_flag_q <= 1'b1;
      if (rx_fer) fer_q <= 1'b1;
      if (rx_per) per_q <= 1'b1;
      if (rx_take & mp_fmt) mpb_q <= rx_extra_q;
    end
  end

  // ---------- interrupt levels ----------
  assign o_tx_empty_irq = tx_buffer_empty_flag_q & ctl_q[`SMU_CTL_TIE] & te;
  assign o_tx_end_irq = tx_end_flag_q & ctl_q[`SMU_CTL_TX_END_IRQ_ENABLE];
  assign o_rx_full_irq = rx_full_flag_q & ctl_q[`SMU_CTL_RIE];
  assign o_rx_error_irq = (overrun_flag_q | fer_q | per_q) & ctl_q[`SMU_CTL_RIE];
endmodule
`default_nettype wire

// [smu_defs.vh]
// Purpose: register map, field positions, reset values and timing for the async serial unit
// Assumes: 32-bit AHB-Lite register access, 100 MHz clock
// Notes: all offsets are byte addresses of aligned words
// Functional notes
// - clearing tx enable forces tx buffer empty flag to 1.
// - clearing rx enable leaves rx flags and rx buffer untouched.
// - transmitter loads shift register when tx buffer empty flag reads 0.
// - after load, set empty flag, start sending, tx empty irq if enabled.
// - frame is start, data, optional parity or multiproc bit, stop bits.
// - at stop bit with flag 0, load next byte, start next frame immediately.
// - at stop bit with flag 1, set tx end, idle mark, end irq.
// - receiver finds start bit, resyncs, shifts bits, checks parity and stop.
// - frame done while rx full: set overrun, drop data, keep full, error irq.
// - parity mismatch sets parity error, still stores data, error irq.
// - stop bit 0 sets framing error, still stores data, error irq.
// - clean frame stores data, sets rx full, rx full irq.
// - on any error rx full keeps prior value; overrun loses data.
// - no reception while any error flag set; software clears flags.
// - multiproc bit 1 marks an id frame, 0 a data frame.
// - multiproc wait suppresses store, errors and flags until id frame.
// - id frame sets rx multiproc bit, clears wait, stores data, rx irq.
// - multiproc format ignores parity enable.
// - transmitted multiproc bit equals software's tx multiproc bit.
// - 16x basic clock, start edge detect, sample on 8th pulse mid-bit.
// - line idles high; start bit low; one or two high stop bits.
// - twelve formats: 7/8 data, parity, multiproc, 1/2 stop bits.
`ifndef SMU_DEFS_VH
`define SMU_DEFS_VH
`define SMU_ADDR_FORMAT 4'h0
`define SMU_ADDR_CONTROL 4'h4
`define SMU_ADDR_STATUS 4'h8
`define SMU_ADDR_TXDATA 4'hC
`define SMU_ADDR_RXDATA 4'h0
`define SMU_ADDR_DIVIDER 4'h4
// format register fields
`define SMU_FMT_STOP2 0
`define SMU_FMT_MP 1
`define SMU_FMT_PODD 2
`define SMU_FMT_PE 3
`define SMU_FMT_CHR7 4
// control register fields
`define SMU_CTL_TE 0
`define SMU_CTL_RE 1
`define SMU_CTL_MULTIPROC_WAIT_ENABLE 2
`define SMU_CTL_TX_END_IRQ_ENABLE 3
`define SMU_CTL_RIE 4
`define SMU_CTL_TIE 5
// status register fields
`define SMU_ST_TX_MULTIPROC_BIT 0
`define SMU_ST_MPB 1
`define SMU_ST_TX_END_FLAG 2
`define SMU_ST_PER 3
`define SMU_ST_FER 4
`define SMU_ST_OVERRUN_FLAG 5
`define SMU_ST_RX_FULL_FLAG 6
`define SMU_ST_TX_BUFFER_EMPTY_FLAG 7
`define SMU_RST_STATUS 8'h84
`define SMU_RST_DIVIDER 16'h0035
`define SMU_OVERSAMPLE 16
`define SMU_MID_TICK 4'h7
`define SMU_LAST_TICK 4'hF
`endif

// [smu_tick_gen.v]
// Purpose: basic clock tick at 16x bit rate from the system clock
// Assumes: divider value programmed by software, 0 gives a tick every clock
// Notes: tick is a one-cycle pulse every divider+1 clocks
`timescale 1ns/1ps
`default_nettype none
module smu_tick_gen (
  // clock and reset
  input wire i_clk,
  input wire i_arst_n,
  // control
  input wire [15:0] i_div,
  output reg o_tick
);
  reg [15:0] cnt_q;
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_q <= 16'h0000;
      o_tick <= 1'b0;
    end else if (cnt_q >= i_div) begin
      cnt_q <= 16'h0000;
      o_tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      o_tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [smu_rx_sync.v]
// Purpose: two-flop synchroniser for the receive line
// Assumes: line idles high
// Notes: resets to mark so no false start bit appears
`timescale 1ns/1ps
`default_nettype none
module smu_rx_sync (
  // clock and reset
  input wire i_clk,
  input wire i_arst_n,
  // line
  input wire i_line,
  output reg o_line
);
  reg meta_q;
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_q <= 1'b1;
      o_line <= 1'b1;
    end else begin
      meta_q <= i_line;
      o_line <= meta_q;
    end
  end
endmodule
`default_nettype wire

// [smu_serial_comm_unit_sva.sv]
// Purpose: port-level checks for the async serial unit
// Assumes: irq enables are set before the flags they gate
// Notes: bit lengths hold at any divider, since a bit is 16 ticks of at least one clock
`timescale 1ns/1ps
`default_nettype none
module smu_serial_comm_unit_sva (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // bus
  input wire logic i_hsel,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  // serial lines and irqs
  input wire logic i_rxd,
  input wire logic o_txd,
  input wire logic o_tx_empty_irq,
  input wire logic o_tx_end_irq,
  input wire logic o_rx_full_irq,
  input wire logic o_rx_error_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  wire bus_wr = i_hsel && i_htrans[1] && i_hwrite;

  property p_zero_wait; o_hreadyout && !o_hresp; endproperty
  a_zero_wait: assert property (p_zero_wait)
    else $error("bus slave stalled or errored");
  property p_idle_reset; $rose(i_arst_n) |-> o_txd; endproperty
  a_idle_reset: assert property (p_idle_reset)
    else $error("tx line not at mark after reset");
  property p_end_mark; o_tx_end_irq |-> o_txd; endproperty
  a_end_mark: assert property (p_end_mark)
    else $error("tx end irq while line not at mark");
  property p_end_clear; $fell(o_tx_end_irq) |-> $past(bus_wr, 2); endproperty
  a_end_clear: assert property (p_end_clear)
    else $error("tx end irq dropped without a bus write");
  property p_low_len; $fell(o_txd) |=> !o_txd [*7]; endproperty
  a_low_len: assert property (p_low_len)
    else $error("low bit on tx line too short");
  property p_high_len; $rose(o_txd) |=> o_txd [*7]; endproperty
  a_high_len: assert property (p_high_len)
    else $error("high bit on tx line too short");
  property p_err_full; $rose(o_rx_error_irq) |-> $stable(o_rx_full_irq); endproperty
  a_err_full: assert property (p_err_full)
    else $error("rx full changed with a receive error");
  property p_full_stop; $rose(o_rx_full_irq) |-> i_rxd && $past(i_rxd, 3); endproperty
  a_full_stop: assert property (p_full_stop)
    else $error("rx full raised outside a stop bit");

  c_tx_end: cover property ($rose(o_tx_end_irq));
  c_tx_empty: cover property ($rose(o_tx_empty_irq));
  c_rx_full: cover property ($rose(o_rx_full_irq));
  c_rx_err: cover property ($rose(o_rx_error_irq));
endmodule
`default_nettype wire

// [smu_remote_station.sv]
// Purpose: remote async station on the two serial lines
// Assumes: bit time is BIT_CLKS system clocks
// Notes: line returns to mark after each frame, as a pulled-up line would
`timescale 1ns/1ps
`default_nettype none
module smu_remote_station #(
  parameter int BIT_CLKS = 32
) (
  // clock
  input wire logic i_clk,
  // lines
  output logic o_line,
  input wire logic i_line
);
  int rx_len = 9;
  int frames = 0;
  logic [11:0] got = 12'h000;
  realtime t_prev = 0;
  realtime t_last = 0;

  initial o_line = 1'b1;

  // start bit, then n bits lsb first; the caller picks the stop level
  task automatic send(input logic [11:0] b, input int n);
    o_line <= 1'b0;
    repeat (BIT_CLKS) @(posedge i_clk);
    for (int i = 0; i < n; i++) begin
      o_line <= b[i];
      repeat (BIT_CLKS) @(posedge i_clk);
    end
    o_line <= 1'b1;
  endtask

  // mid-bit sampling keeps a one-tick start skew harmless
  initial forever begin
    @(negedge i_line);
    t_prev = t_last;
    t_last = $realtime;
    repeat (BIT_CLKS / 2) @(posedge i_clk);
    for (int i = 0; i < rx_len; i++) begin
      repeat (BIT_CLKS) @(posedge i_clk);
      got[i] = i_line;
    end
    frames++;
  end
endmodule
`default_nettype wire

// [smu_serial_comm_unit_bench.sv]
// Purpose: self-checking bench for the async serial unit
// Assumes: divider set to 1, so one bit is 32 clocks
// Notes: hsize is tied to word; the remote station plays the far end
`timescale 1ns/1ps
`default_nettype none
module smu_serial_comm_unit_bench;
  localparam int BIT = 32;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rv;
  logic [11:0] fb;
  wire [31:0] hrdata;
  wire hready, hresp, txd, rxd, irq_te, irq_tx_end_flag, irq_rf, irq_re;
  int n_errors = 0;
  int check_count = 0;
  int nb;

  smu_serial_comm_unit i_smu_serial_comm_unit (
    .i_clk(clk), .i_arst_n(arst_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(hresp), .i_rxd(rxd), .o_txd(txd), .o_tx_empty_irq(irq_te),
    .o_tx_end_irq(irq_tx_end_flag), .o_rx_full_irq(irq_rf), .o_rx_error_irq(irq_re));
  smu_remote_station #(.BIT_CLKS(BIT)) i_smu_remote_station (.i_clk(clk), .o_line(rxd), .i_line(txd));

  initial forever #5 clk = ~clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic clks(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clk);
    while (!hready) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (!hready) @(posedge clk);
    rv = hrdata;
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rv & m, exp);
  endtask

  // reconfigure with both enables off first
  task automatic setup(input logic [31:0] f, input logic [31:0] c);
    bus(1'b1, 32'h4, 32'h0);
    bus(1'b1, 32'h0, f);
    bus(1'b1, 32'h4, c);
  endtask

  task automatic wait_frame(input int c);
    for (int j = 0; j < 1000 && i_smu_remote_station.frames == c; j++) @(posedge clk);
    chk(i_smu_remote_station.frames - c, 32'h1);
  endtask

  // frame bits after the start bit, lsb first; returns their count
  function automatic int mk(input logic [7:0] d, input logic [4:0] f, input logic rx_multiproc_bit, input logic sv,
                            output logic [11:0] b);
    int n;
    n = f[4] ? 7 : 8;
    b = {4'h0, d};
    if (f[4]) b[7] = 1'b0;
    if (f[1]) b[n] = rx_multiproc_bit;
    else if (f[3]) b[n] = (^b[7:0]) ^ f[2];
    if (f[1] | f[3]) n++;
    b[n] = sv;
    n++;
    if (f[0]) b[n] = 1'b1;
    if (f[0]) n++;
    return n;
  endfunction

  task automatic rx(input logic [7:0] d, input logic [4:0] f, input logic rx_multiproc_bit, input logic sv);
    nb = mk(d, f, rx_multiproc_bit, sv, fb);
    i_smu_remote_station.send(fb, nb);
    clks(4);
  endtask

  task automatic t_reset;
    rd_chk(32'h8, 32'hFF, 32'h84);
    rd_chk(32'h14, 32'hFFFF, 32'h35);
    rd_chk(32'h18, 32'hFFFFFFFF, 32'h0);
    bus(1'b1, 32'h14, 32'h1);
    $display("test reset done");
  endtask

  task automatic t_tx;
    logic [4:0] f [4] = '{5'h00, 5'h19, 5'h0C, 5'h0B};
    logic [7:0] d [4] = '{8'hA5, 8'hC3, 8'h96, 8'h5E};
    int c;
    for (int k = 0; k < 4; k++) begin
      setup({27'h0, f[k]}, 32'h29);
      bus(1'b1, 32'h8, {24'h0, 7'h7F, k == 3});
      nb = mk(d[k], f[k], k == 3, 1'b1, fb);
      i_smu_remote_station.rx_len = nb;
      c = i_smu_remote_station.frames;
      bus(1'b1, 32'hC, {24'h0, d[k]});
      clks(3);
      chk(irq_te, 1'b1);
      wait_frame(c);
      chk({20'h0, i_smu_remote_station.got} & ((32'h1 << nb) - 32'h1), {20'h0, fb});
      clks(BIT);
      chk(irq_tx_end_flag, 1'b1);
    end
    $display("test tx formats done");
  endtask

  task automatic t_b2b;
    int c;
    realtime dt;
    setup(32'h0, 32'h29);
    i_smu_remote_station.rx_len = 9;
    c = i_smu_remote_station.frames;
    bus(1'b1, 32'hC, 32'h81);
    clks(1);
    chk(irq_tx_end_flag, 1'b0);
    clks(3);
    bus(1'b1, 32'hC, 32'h7E);
    wait_frame(c);
    wait_frame(c + 1);
    dt = i_smu_remote_station.t_last - i_smu_remote_station.t_prev;
    chk(dt >= 3180.0 && dt <= 3220.0, 1'b1);
    nb = mk(8'h7E, 5'h00, 1'b0, 1'b1, fb);
    chk({20'h0, i_smu_remote_station.got} & 32'h1FF, {20'h0, fb});
    clks(BIT);
    $display("test back to back done");
  endtask

  task automatic t_rx_clean;
    setup(32'h0, 32'h12);
    rx(8'h3C, 5'h00, 1'b0, 1'b1);
    chk(irq_rf, 1'b1);
    rd_chk(32'h10, 32'hFF, 32'h3C);
    rx(8'h5A, 5'h00, 1'b0, 1'b1);
    chk(irq_re, 1'b1);
    rd_chk(32'h10, 32'hFF, 32'h3C);
    rd_chk(32'h8, 32'h78, 32'h60);
    bus(1'b1, 32'h4, 32'h10);
    rd_chk(32'h8, 32'h78, 32'h60);
    bus(1'b1, 32'h4, 32'h12);
    rx(8'h11, 5'h00, 1'b0, 1'b1);
    rd_chk(32'h10, 32'hFF, 32'h3C);
    bus(1'b1, 32'h8, 32'h0);
    rd_chk(32'h8, 32'h78, 32'h0);
    $display("test rx overrun done");
  endtask

  task automatic t_rx_err;
    setup(32'h8, 32'h12);
    for (int k = 0; k < 2; k++) begin
      nb = mk(8'h81 + k, 5'h08, 1'b0, k == 0, fb);
      if (k == 0) fb[8] = ~fb[8];
      i_smu_remote_station.send(fb, nb);
      clks(4);
      chk(irq_re, 1'b1);
      rd_chk(32'h10, 32'hFF, 32'h81 + k);
      rd_chk(32'h8, 32'h78, k == 0 ? 32'h08 : 32'h10);
      bus(1'b1, 32'h8, 32'h0);
    end
    $display("test rx errors done");
  endtask

  task automatic t_mp;
    setup(32'h2, 32'h16);
    rx(8'h44, 5'h02, 1'b0, 1'b0);
    rd_chk(32'h8, 32'h7A, 32'h0);
    rx(8'h77, 5'h02, 1'b1, 1'b1);
    chk(irq_rf, 1'b1);
    rd_chk(32'h8, 32'h7A, 32'h42);
    rd_chk(32'h4, 32'h4, 32'h0);
    rd_chk(32'h10, 32'hFF, 32'h77);
    bus(1'b1, 32'h8, 32'h0);
    $display("test multiprocessor done");
  endtask

  // te is dropped while data bits are high, so an aborted frame leaves no short bit
  task automatic t_te_off;
    setup(32'h0, 32'h1);
    bus(1'b1, 32'hC, 32'hFF);
    clks(3);
    bus(1'b1, 32'hC, 32'h0);
    rd_chk(32'h8, 32'h80, 32'h0);
    clks(100);
    bus(1'b1, 32'h4, 32'h0);
    rd_chk(32'h8, 32'h80, 32'h80);
    $display("test tx disable done");
  endtask

  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    clks(5);
    arst_n <= 1'b1;
    t_reset;
    t_tx;
    t_b2b;
    t_rx_clean;
    t_rx_err;
    t_mp;
    t_te_off;
    print_verdict;
  end

  initial begin
    #500000;
    n_errors++;
    print_verdict;
  end
endmodule

bind smu_serial_comm_unit smu_serial_comm_unit_sva i_smu_serial_comm_unit_sva (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_hsel(i_hsel), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
  .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_rxd(i_rxd), .o_txd(o_txd),
  .o_tx_empty_irq(o_tx_empty_irq), .o_tx_end_irq(o_tx_end_irq), .o_rx_full_irq(o_rx_full_irq),
  .o_rx_error_irq(o_rx_error_irq));
`default_nettype wire
